/* File: hdl/gdpc_counter.sv */
// Contract
// - in gated mode a source edge counts only while the gate is active.
// - in gated mode source edges are ignored unless the counter is armed.
// - in gated mode the first terminal count reloads from hold and counting goes on.
// - in gated mode the second terminal count reloads from load and disarms.
// - in triggered mode an armed counter counts nothing before a gate edge.
// - in triggered mode gate edges while disarmed are ignored.
// - in triggered mode decrementing starts on the first source edge after the gate edge.
// - once triggered, triggered mode runs the same hold-then-load two-phase sequence.
// - in triggered mode the counter disarms at the second terminal count.
// - after the trigger the gate is ignored until the second terminal count.
// - terminal count fires on the source edge taken while the count equals one.
// - after reset the setup register holds the count-down binary once no-gating preset.
`timescale 1ns/10ps
`default_nettype none
module gdpc_counter
  import gdpc_pkg::*;
#(
  parameter int WIDTH = CNT_W
) (
  input  wire logic                  clk_sys,
  input  wire logic                  srst,
  input  wire gdpc_pkg::gdpc_mode_t  mode,
  input  wire logic                  cmd_arm,
  input  wire logic                  cmd_disarm,
  input  wire logic                  cmd_load,
  input  wire logic [WIDTH-1:0]      load_val,
  input  wire logic [WIDTH-1:0]      hold_val,
  input  wire logic                  setup_we,
  input  wire logic [15:0]           setup_wdata,
  input  wire logic                  src_in,
  input  wire logic                  gate_in,
  output logic [15:0]                counter_setup_register,
  output logic [WIDTH-1:0]           count,
  output logic                       armed,
  output logic                       terminal_count,
  output logic                       out_toggle
);
  import gdpc_pkg::*;

  // terminal count compare needs at least two bits, and the preset constants are 16 bits
  if (WIDTH < 2 || WIDTH > 16) begin : g_width_check
    $error("gdpc_counter: WIDTH must be 2 to 16");
  end

  logic              src_rise;
  logic              gate_rise;
  gdpc_state_t       state_q;
  logic [WIDTH-1:0]  count_q;
  logic [15:0]       setup_q;
  logic              tc_q;
  logic              tog_q;
  logic              counting;
  logic              at_tc;
  logic              step;

  gdpc_edge u_src (
    .clk_sys (clk_sys),
    .srst    (srst),
    .sig_in  (src_in),
    .rise    (src_rise)
  );

  gdpc_edge u_gate (
    .clk_sys (clk_sys),
    .srst    (srst),
    .sig_in  (gate_in),
    .rise    (gate_rise)
  );

  assign counting = (state_q == GDPC_ST_DELAY) || (state_q == GDPC_ST_PULSE);
  // gated mode qualifies source edges by gate level; triggered mode ignores gate
  assign step = counting && src_rise &&
                ((mode == GDPC_MODE_GATED) ? gate_in : 1'b1);
  assign at_tc = step && (count_q == TC_COUNT_VAL[WIDTH-1:0]);

  // setup register, written by host only while disarmed
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      setup_q <= SETUP_RESET;
    end else if (setup_we && (state_q == GDPC_ST_DISARMED)) begin
      setup_q <= setup_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= GDPC_ST_DISARMED;
    end else if (cmd_disarm) begin
      state_q <= GDPC_ST_DISARMED;
    end else begin
      case (state_q)
        GDPC_ST_DISARMED: begin
          if (cmd_arm && mode == GDPC_MODE_GATED) begin
            state_q <= GDPC_ST_DELAY;
          end else if (cmd_arm && mode == GDPC_MODE_TRIG) begin
            state_q <= GDPC_ST_WAIT_TRIG;
          end
        end
        GDPC_ST_WAIT_TRIG: begin
          if (gate_rise) begin
            state_q <= GDPC_ST_DELAY;
          end
        end
        GDPC_ST_DELAY: begin
          if (at_tc) begin
            state_q <= GDPC_ST_PULSE;
          end
        end
        GDPC_ST_PULSE: begin
          if (at_tc) begin
            state_q <= GDPC_ST_DISARMED;
          end
        end
        default: state_q <= GDPC_ST_DISARMED;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      count_q <= CNT_RESET[WIDTH-1:0];
    end else if (at_tc && state_q == GDPC_ST_DELAY) begin
      count_q <= hold_val;
    end else if (at_tc) begin
      count_q <= load_val;
    end else if (step) begin
      count_q <= count_q - 1'b1;
    end else if (cmd_load && !counting) begin
      count_q <= load_val;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tc_q  <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      tc_q <= at_tc;
      if (at_tc) begin
        tog_q <= ~tog_q;
      end
    end
  end

  assign counter_setup_register = setup_q;
  assign count                  = count_q;
  assign armed                  = (state_q != GDPC_ST_DISARMED);
  assign terminal_count         = tc_q;
  assign out_toggle             = tog_q;

  a_gate_pause: assert property (@(posedge clk_sys) disable iff (srst)
    (counting && mode == GDPC_MODE_GATED && src_rise && !gate_in && !cmd_disarm)
      |=> $stable(count_q))
    else $error("count moved with gate inactive");

  a_idle_hold: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == GDPC_ST_DISARMED && !cmd_load) |=> $stable(count_q))
    else $error("disarmed counter changed");

  a_hold_reload: assert property (@(posedge clk_sys) disable iff (srst)
    (at_tc && state_q == GDPC_ST_DELAY && !cmd_disarm)
      |=> (count_q == $past(hold_val) && state_q == GDPC_ST_PULSE))
    else $error("first terminal count did not reload hold");

  a_load_disarm: assert property (@(posedge clk_sys) disable iff (srst)
    (at_tc && state_q == GDPC_ST_PULSE)
      |=> (count_q == $past(load_val) && !armed))
    else $error("second terminal count did not reload load and disarm");

  // a host preload while waiting is not counting, so it is left out
  a_wait_still: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == GDPC_ST_WAIT_TRIG && !cmd_load) |=> $stable(count_q))
    else $error("count moved before trigger");

  a_disarm_gate: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == GDPC_ST_DISARMED && !cmd_arm) |=> !armed)
    else $error("gate edge started disarmed counter");

  a_gate_ignored: assert property (@(posedge clk_sys) disable iff (srst)
    (state_q == GDPC_ST_DISARMED && gate_rise && !cmd_arm) |=> !armed)
    else $error("gate edge armed a disarmed counter");

  sequence s_trigger;
    state_q == GDPC_ST_WAIT_TRIG && gate_rise && !cmd_disarm && !cmd_load;
  endsequence

  // the trigger edge itself counts nothing; the next source edge decrements
  a_trig_start: assert property (@(posedge clk_sys) disable iff (srst)
    s_trigger |=> (state_q == GDPC_ST_DELAY && $stable(count_q)))
    else $error("trigger edge did not start counting cleanly");

  a_trig_ignore: assert property (@(posedge clk_sys) disable iff (srst)
    (counting && mode == GDPC_MODE_TRIG && src_rise && !cmd_disarm
     && count_q != TC_COUNT_VAL[WIDTH-1:0])
      |=> (count_q == $past(count_q) - 1'b1))
    else $error("triggered count depended on gate");

  sequence s_tc_out;
    terminal_count && out_toggle != $past(out_toggle);
  endsequence

  a_tc_pulse: assert property (@(posedge clk_sys) disable iff (srst)
    at_tc |=> s_tc_out ##1 !terminal_count)
    else $error("terminal count pulse or toggle wrong");

  a_tc_quiet: assert property (@(posedge clk_sys) disable iff (srst)
    (step && count_q != TC_COUNT_VAL[WIDTH-1:0]) |=> !terminal_count)
    else $error("terminal count away from count of one");

  a_setup_lock: assert property (@(posedge clk_sys) disable iff (srst)
    (armed && !cmd_disarm) |=> $stable(counter_setup_register))
    else $error("setup changed while armed");

  a_arm_sets: assert property (@(posedge clk_sys) disable iff (srst)
    (!armed && cmd_arm && !cmd_disarm && mode != GDPC_MODE_IDLE) |=> armed)
    else $error("arm command did not arm");

  a_arm_gated: assert property (@(posedge clk_sys) disable iff (srst)
    (!armed && cmd_arm && !cmd_disarm && mode == GDPC_MODE_GATED)
      |=> (state_q == GDPC_ST_DELAY))
    else $error("gated arm did not start counting phase");

  a_reset_setup: assert property (@(posedge clk_sys)
    srst |=> (counter_setup_register == SETUP_RESET))
    else $error("setup preset wrong after reset");
endmodule
`default_nettype wire

/* File: hdl/gdpc_pkg.sv */
package gdpc_pkg;
  localparam int          CNT_W         = 16;
  // counter setup preset after reset: count down, binary, once, no gating
  localparam logic [15:0] SETUP_RESET   = 16'h0800;
  localparam logic [15:0] CNT_RESET     = 16'h0000;
  localparam logic [15:0] TC_COUNT_VAL  = 16'h0001;

  typedef enum logic [1:0] {
    GDPC_MODE_GATED,
    GDPC_MODE_TRIG,
    GDPC_MODE_IDLE
  } gdpc_mode_t;

  typedef enum {
    GDPC_ST_DISARMED,
    GDPC_ST_WAIT_TRIG,
    GDPC_ST_DELAY,
    GDPC_ST_PULSE
  } gdpc_state_t;
endpackage

/* File: hdl/gdpc_edge.sv */
`timescale 1ns/10ps
`default_nettype none
// rising-edge detector on a synchronous input
module gdpc_edge (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic sig_in,
  output logic      rise
);
  logic sig_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sig_q <= 1'b0;
    end else begin
      sig_q <= sig_in;
    end
  end

  assign rise = sig_in & ~sig_q;
endmodule
`default_nettype wire

/* File: testbench/gdpc_src_model.sv */
`timescale 1ns/10ps
`default_nettype none
// count source: one rising edge every two cycles while run is high
module gdpc_src_model (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic run,
  output logic      src_in
);
  always_ff @(posedge clk_sys) begin
    if (srst || !run) begin
      src_in <= 1'b0;
    end else begin
      src_in <= !src_in;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/gated_delayed_pulse_counter_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module gated_delayed_pulse_counter_tb;
  import gdpc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  gdpc_mode_t  mode = GDPC_MODE_GATED;
  logic        cmd_arm = 1'b0, cmd_disarm = 1'b0, cmd_load = 1'b0, setup_we = 1'b0;
  logic [15:0] load_val = 16'h0000, hold_val = 16'h0000, setup_wdata = 16'h0000;
  logic        run = 1'b0, gate_in = 1'b0, src_in;
  logic [15:0] counter_setup_register, count;
  logic        armed, terminal_count, out_toggle;
  int          num_errors = 0, compares = 0, tc_seen = 0, tc0;

  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (terminal_count === 1'b1) tc_seen++;

  gdpc_src_model src_model (.clk_sys(clk_sys), .srst(srst), .run(run), .src_in(src_in));
  gdpc_counter uut (.clk_sys(clk_sys), .srst(srst), .mode(mode), .cmd_arm(cmd_arm),
    .cmd_disarm(cmd_disarm), .cmd_load(cmd_load), .load_val(load_val), .hold_val(hold_val),
    .setup_we(setup_we), .setup_wdata(setup_wdata), .src_in(src_in), .gate_in(gate_in),
    .counter_setup_register(counter_setup_register), .count(count), .armed(armed),
    .terminal_count(terminal_count), .out_toggle(out_toggle));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // 0 arm, 1 disarm, 2 load, 3 setup write
  task automatic strobe(input int k);
    case (k)
      0: cmd_arm = 1'b1;
      1: cmd_disarm = 1'b1;
      2: cmd_load = 1'b1;
      default: setup_we = 1'b1;
    endcase
    tick(1);
    {cmd_arm, cmd_disarm, cmd_load, setup_we} = 4'h0;
    tick(2);
  endtask
  task automatic pulses(input int n);
    run = 1'b1;
    tick(2 * n);
    run = 1'b0;
    tick(3);
  endtask
  task automatic gate_edge();
    gate_in = 1'b1;
    tick(2);
    gate_in = 1'b0;
    tick(2);
  endtask

  task automatic t_reset();
    chk("setup", counter_setup_register, SETUP_RESET);
    chk("count", count, CNT_RESET);
    chk("armed", {15'h0000, armed}, 16'h0000);
    $display("test reset done");
  endtask
  task automatic t_gated();
    load_val = 16'h0002;
    hold_val = 16'h0003;
    strobe(2);
    tc0 = tc_seen;
    strobe(0);
    chk("armed", {15'h0000, armed}, 16'h0001);
    pulses(3);
    chk("count", count, 16'h0002);
    gate_in = 1'b1;
    pulses(1);
    chk("count", count, 16'h0001);
    pulses(1);
    chk("count", count, 16'h0003);
    chk("toggle", {15'h0000, out_toggle}, 16'h0001);
    setup_wdata = 16'h1234;
    strobe(3);
    chk("setup", counter_setup_register, SETUP_RESET);
    gate_in = 1'b0;
    pulses(2);
    gate_in = 1'b1;
    pulses(3);
    chk("count", count, 16'h0002);
    chk("armed", {15'h0000, armed}, 16'h0000);
    chk("toggle", {15'h0000, out_toggle}, 16'h0000);
    chk("tc", tc_seen[15:0] - tc0[15:0], 16'h0002);
    pulses(2);
    chk("count", count, 16'h0002);
    gate_in = 1'b0;
    $display("test gated done");
  endtask
  task automatic t_trig();
    mode = GDPC_MODE_TRIG;
    tick(1);
    gate_edge();
    strobe(0);
    pulses(2);
    chk("count", count, 16'h0002);
    chk("armed", {15'h0000, armed}, 16'h0001);
    gate_edge();
    pulses(1);
    chk("count", count, 16'h0001);
    pulses(1);
    chk("count", count, 16'h0003);
    gate_edge();
    pulses(2);
    chk("count", count, 16'h0001);
    pulses(1);
    chk("count", count, 16'h0002);
    chk("armed", {15'h0000, armed}, 16'h0000);
    $display("test trig done");
  endtask
  task automatic t_disarm();
    strobe(0);
    strobe(1);
    chk("armed", {15'h0000, armed}, 16'h0000);
    gate_edge();
    pulses(2);
    chk("count", count, 16'h0002);
    setup_wdata = 16'h0a5a;
    strobe(3);
    chk("setup", counter_setup_register, 16'h0a5a);
    $display("test disarm done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    tick(20);
    srst = 1'b0;
    tick(2);
    t_reset();
    t_gated();
    t_trig();
    t_disarm();
    summarize();
  end
endmodule
`default_nettype wire
